// File: bench/acr_ctrl_bench.sv
// self-checking bench for the conversion control block
module acr_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, step_en = 0, halt_req = 1;
    logic [3:0] adr_i = 0, sel_i = 0, input_sel_o;
    logic [31:0] dat_i = 0, dat_o;
    logic ack_o, acquisition_halt_pin_i, seq_step_i, convert_o, single_or_ratiometric_o;
    logic ext_ref_o, busy_o, settle_o, acq_halted_o;
    logic [4:0] readback_sel_o;
    logic [11:0] v, v2;
    logic [31:0] rq[$], dq[$];
    int fails = 0, n_compared = 0, run_len = 0, seed = 32'h8db7, n;
    always #20 clk_i = ~clk_i;
    acr_ctrl #(.CCLK_DIV(1)) acr_ctrl_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .acquisition_halt_pin_i, .seq_step_i, .convert_o, .input_sel_o,
        .single_or_ratiometric_o, .ext_ref_o, .busy_o, .settle_o, .readback_sel_o, .acq_halted_o);
    acr_host_model acr_host_model_inst (.clk_i, .convert_i(convert_o), .step_en_i(step_en),
        .halt_req_i(halt_req), .seq_step_o(seq_step_i), .halt_pin_o(acquisition_halt_pin_i));
    task automatic final_report();
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [11:0] d, input logic [11:0] e);
        int k;
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h3;
        dat_i <= {20'h00000, d};
        if (!w) rq.push_back({20'h00000, e});
        k = 0;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && k < 50) begin
            k++;
            @(posedge clk_i);
        end
        if (k >= 50) begin
            fails++;
            final_report();
        end
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic wait_lvl(input logic lv, input int lim);
        n = 0;
        while (convert_o !== lv && n < lim) begin
            n++;
            @(posedge clk_i);
        end
        if (n >= lim) begin
            fails++;
            final_report();
        end
    endtask
    // read data compared in ack order
    always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0 && rq.size() > 0) chk("read", rq.pop_front(), dat_o);
    always @(posedge clk_i) begin
        if (settle_o === 1'b1) run_len++;
        else if (run_len > 0) begin
            if (dq.size() > 0) chk("settle_len", dq.pop_front(), run_len);
            run_len = 0;
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        wb(0, 4'h4, 12'h000, 12'h000);
        wb(0, 4'h8, 12'h000, 12'h000);
        wb(1, 4'h0, 12'hFFF, 12'h000);
        wb(0, 4'h0, 12'h000, 12'h000);
        for (int i = 0; i < 11; i++) begin
            v = $random(seed);
            v2 = $random(seed);
            v[1:0] = 2'h0;
            v[10:7] = i;
            halt_req <= $random(seed);
            wb(1, 4'h4, v, 12'h000);
            wb(1, 4'h8, v2, 12'h000);
            wb(0, 4'h4, 12'h000, v);
            wb(0, 4'h8, 12'h000, v2);
            chk("input_sel", i, input_sel_o);
            chk("readback_sel", v[6:2], readback_sel_o);
            chk("single_or_ratiometric", v[11], single_or_ratiometric_o);
            chk("ext_ref", v2[2], ext_ref_o);
            chk("acq_halted", v2[3] ? halt_req : !halt_req, acq_halted_o);
            chk("busy_idle", 0, busy_o);
        end
        halt_req <= 1;
        for (int i = 0; i < 4; i++) begin
            n = i == 0 ? 1 : (i == 1 ? 256 : (i == 2 ? 2048 : 16384));
            dq.push_back(n);
            dq.push_back(n);
            wb(1, 4'h8, {6'h00, i[1:0], 4'h0}, 12'h000);
            wb(1, 4'h4, 12'h001, 12'h000);
            for (int k = 0; k < 40000 && busy_o !== 1'b0; k++) @(posedge clk_i);
            chk("busy_done", 0, busy_o);
            if (busy_o !== 1'b0) final_report();
        end
        wb(0, 4'hC, 12'h000, 12'h010);
        // self-timed repeat: every 1024 periods, so the gap includes one interval
        wb(1, 4'h8, 12'h001, 12'h000);
        wb(1, 4'h4, 12'h183, 12'h000);
        wait_lvl(1, 200);
        wait_lvl(0, 200);
        wait_lvl(1, 1200);
        chk("interval_gap", 1, n >= 1024 && n <= 1100);
        wb(1, 4'h8, 12'h000, 12'h000);
        step_en <= 1;
        wb(1, 4'h4, 12'h182, 12'h000);
        wait_lvl(0, 200);
        wait_lvl(1, 200);
        wait_lvl(0, 200);
        wait_lvl(1, 200);
        final_report();
    end
endmodule // acr_ctrl_bench

// File: bench/acr_ctrl_sva.sv
// port assertions for the conversion control block
module acr_ctrl_sva (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [3:0]  adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i,
    input wire        ack_o,
    input wire        acquisition_halt_pin_i,
    input wire        convert_o,
    input wire [3:0]  input_sel_o,
    input wire        single_or_ratiometric_o,
    input wire        ext_ref_o,
    input wire        busy_o,
    input wire        settle_o,
    input wire [4:0]  readback_sel_o,
    input wire        acq_halted_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // fields captured at the accepting edge, like the registers
    logic [4:0] c1_r;
    logic [1:0] c2_r;
    wire        take = cyc_i && stb_i && !ack_o;
    wire        wr1  = take && we_i && adr_i[3:2] == 2'h1 && sel_i == 4'h3;
    wire        wr2  = take && we_i && adr_i[3:2] == 2'h2 && sel_i[0];
    always @(posedge clk_i) begin
        c1_r <= rst_i ? 5'h00 : (wr1 ? dat_i[11:7] : c1_r);
        c2_r <= rst_i ? 2'h0 : (wr2 ? dat_i[3:2] : c2_r);
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (take |=> ack_o) else $error("no ack after request");
    a_readback_field: assert property (wr1 |=> readback_sel_o == $past(dat_i[6:2])) else $error("readback");
    a_channel_code: assert property (wr1 |-> ##2 input_sel_o == c1_r[3:0]) else $error("channel code");
    a_conv_kind: assert property (wr1 |-> ##2 single_or_ratiometric_o == c1_r[4]) else $error("conv kind");
    a_ref_select: assert property (wr2 |-> ##2 ext_ref_o == c2_r[0]) else $error("reference select");
    a_halt_level: assert property (acq_halted_o == (c2_r[1] ~^ acquisition_halt_pin_i)) else $error("halt");
    a_conv_busy: assert property (convert_o |-> busy_o) else $error("convert while idle");
    a_settle_apart: assert property (settle_o |-> busy_o && !convert_o) else $error("settle overlap");
    a_reset_idle: assert property ($fell(rst_i) |-> !busy_o && !convert_o) else $error("busy after reset");
    a_start_busy: assert property (wr1 && dat_i[1:0] != 2'h0 && !busy_o |-> ##2 busy_o)
        else $error("write with mode did not start");
    a_mode_none: assert property (wr1 && dat_i[1:0] == 2'h0 && !busy_o |-> ##2 !busy_o)
        else $error("mode zero started a conversion");
endmodule // acr_ctrl_sva

bind acr_ctrl acr_ctrl_sva acr_ctrl_sva_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .ack_o, .acquisition_halt_pin_i, .convert_o, .input_sel_o, .single_or_ratiometric_o, .ext_ref_o,
    .busy_o, .settle_o, .readback_sel_o, .acq_halted_o);

// File: bench/acr_host_model.sv
// host side model: halt pin and host-paced sequence steps
module acr_host_model (
    input  wire  clk_i,
    input  wire  convert_i,
    input  wire  step_en_i,
    input  wire  halt_req_i,
    output logic seq_step_o = 1'b0,
    output logic halt_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic conv_d_r = 1'b0;
    assign halt_pin_o = halt_req_i;
    always @(posedge clk_i) begin
        conv_d_r   <= convert_i;
        seq_step_o <= step_en_i && conv_d_r && !convert_i;
    end
endmodule // acr_host_model

// File: design/acr_cclk_div.v
// conversion-clock tick generator from the system clock
module acr_cclk_div #(
    parameter DIV = 2
) (
    input  wire clk_i,
    input  wire rst_i,
    output reg  tick_o
);
    reg [15:0] cnt_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt_r == DIV[15:0] - 16'h0001) begin
            cnt_r  <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule // acr_cclk_div

// File: design/acr_ctrl.v
// conversion control registers and sequencing timer over classic wishbone
// What this block does
// - Control one bits 1:0 pick no conversion, single, host-paced sequence or self-timed sequence.
// - Control one bits 6:2 hold the readback address, which the host writes before reading a register.
// - Control one bits 10:7 pick the input: 0 X-plus, 1 Y-plus, 3-5 auxiliaries, 6-7 batteries.
// - Codes 2 and 10 pick the pressure nodes, 8 single and 9 differential temperature.
// - Control one bit 11 picks ratiometric at 0 or single-ended at 1.
// - Control two bits 1:0 set converting once or repeating every 1024, 2048 or 16384 periods.
// - Control two bit 2 picks internal reference at 0 or external at 1.
// - Control two bit 3 sets the halt pin active low at 0 or active high at 1.
// - The first delay runs at power-up, before X/Y coordinate channels, and after the last conversion.
// - Delay code 00 gives 1 period and 01 gives 256 periods.
// - Delay code 10 gives 2048 periods and 11 gives 16384 periods.
`include "acr_map.vh"
module acr_ctrl #(
    parameter CCLK_DIV = 2
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    input  wire        acquisition_halt_pin_i,
    input  wire        seq_step_i,
    output reg         convert_o,
    output reg  [3:0]  input_sel_o,
    output reg         single_or_ratiometric_o,
    output reg         ext_ref_o,
    output reg         busy_o,
    output reg         settle_o,
    output wire [4:0]  readback_sel_o,
    output wire        acq_halted_o
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_DELAY = 3'h1;
    localparam ST_CONV  = 3'h2;
    localparam ST_TAIL  = 3'h3;
    localparam ST_WAIT  = 3'h4;
    localparam ST_HOST  = 3'h5;

    reg  [11:0] ctrl1_r;
    reg  [11:0] ctrl2_r;
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [14:0] dly_r;
    reg  [14:0] dly_nxt;
    reg  [14:0] int_r;
    reg  [14:0] int_nxt;
    reg         powered_r;
    reg         powered_nxt;
    reg         start_r;
    wire        cclk_tick;
    wire        req = cyc_i & stb_i & ~ack_o;
    wire [1:0]  mode = ctrl1_r[`ACR_C1_MODE_LSB +: 2];
    wire [1:0]  tmr  = ctrl2_r[`ACR_C2_TMR_LSB +: 2];
    wire [1:0]  fcd  = ctrl2_r[`ACR_C2_FCD_LSB +: 2];
    wire [3:0]  ch   = ctrl1_r[`ACR_C1_CH_LSB +: 4];

    acr_cclk_div #(
        .DIV (CCLK_DIV)
    ) u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (cclk_tick)
    );

    function [14:0] fcd_len;
        input [1:0] code;
        begin
            case (code)
                2'h0:    fcd_len = `ACR_FCD_1;
                2'h1:    fcd_len = `ACR_FCD_256;
                2'h2:    fcd_len = `ACR_FCD_2048;
                default: fcd_len = `ACR_FCD_16384;
            endcase
        end
    endfunction

    function [14:0] int_len;
        input [1:0] code;
        begin
            case (code)
                2'h1:    int_len = `ACR_INT_1024;
                2'h2:    int_len = `ACR_INT_2048;
                2'h3:    int_len = `ACR_INT_16384;
                default: int_len = 15'h0000;
            endcase
        end
    endfunction

    // coordinate channels need the settling delay
    function is_coord;
        input [3:0] code;
        begin
            is_coord = (code == 4'h0) || (code == 4'h1);
        end
    endfunction

    // word index match of a bus address
    function idx_hit;
        input [3:0] adr;
        input [1:0] idx;
        begin
            idx_hit = (adr[3:2] == idx);
        end
    endfunction

    wire        wr_c1 = req & we_i & idx_hit(adr_i, `ACR_IDX_CTRL1);
    wire        wr_c2 = req & we_i & idx_hit(adr_i, `ACR_IDX_CTRL2);
    // status word: halted, powered, busy, state
    wire [31:0] status_w = {26'h0000000, acq_halted_o, powered_r, busy_o, state_r};

    assign acq_halted_o = ctrl2_r[`ACR_C2_POL] ? acquisition_halt_pin_i : ~acquisition_halt_pin_i;
    assign readback_sel_o = ctrl1_r[`ACR_C1_RD_LSB +: 5];

    // register writes; a write with mode nonzero starts conversion
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1_r <= `ACR_CTRL1_RST;
            ctrl2_r <= `ACR_CTRL2_RST;
            start_r <= 1'b0;
            ack_o   <= 1'b0;
        end else begin
            ack_o   <= req;
            start_r <= 1'b0;
            if (wr_c1) begin
                if (sel_i[0])
                    ctrl1_r[7:0] <= dat_i[7:0];
                if (sel_i[1])
                    ctrl1_r[11:8] <= dat_i[11:8];
                start_r <= sel_i[0] & (dat_i[1:0] != 2'h0);
            end
            if (wr_c2) begin
                if (sel_i[0])
                    ctrl2_r[7:0] <= dat_i[7:0];
                if (sel_i[1])
                    ctrl2_r[11:8] <= dat_i[11:8];
            end
        end
    end

    // read data; unmapped reads give zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (req && !we_i) begin
            case (adr_i[3:2])
                `ACR_IDX_CTRL1:  dat_o <= {20'h00000, ctrl1_r};
                `ACR_IDX_CTRL2:  dat_o <= {20'h00000, ctrl2_r};
                `ACR_IDX_STATUS: dat_o <= status_w;
                default:         dat_o <= 32'h00000000;
            endcase
        end
    end

    // sequencer, counters advance only on conversion-clock ticks
    always @* begin
        state_nxt   = state_r;
        dly_nxt     = dly_r;
        int_nxt     = int_r;
        powered_nxt = powered_r;
        case (state_r)
            ST_IDLE: begin
                // settle at power-up or before coordinate channels
                // a start while busy is dropped; mode is re-read at each stage end except the delay
                if (start_r) begin
                    if (!powered_r || is_coord(ch)) begin
                        state_nxt = ST_DELAY;
                        dly_nxt   = fcd_len(fcd);
                    end else begin
                        state_nxt = ST_CONV;
                        dly_nxt   = `ACR_CONV_CYC;
                    end
                    powered_nxt = 1'b1;
                end
            end
            ST_DELAY: begin
                if (cclk_tick) begin
                    if (dly_r <= 15'h0001) begin
                        state_nxt = ST_CONV;
                        dly_nxt   = `ACR_CONV_CYC;
                    end else begin
                        dly_nxt = dly_r - 15'h0001;
                    end
                end
            end
            ST_CONV: begin
                // acquisition frozen while halt asserted
                if (cclk_tick && !acq_halted_o) begin
                    if (dly_r <= 15'h0001) begin
                        // host-paced sequence waits for host step
                        if (mode == 2'h2) begin
                            state_nxt = ST_HOST;
                        end else begin
                            state_nxt = ST_TAIL;
                            dly_nxt   = fcd_len(fcd);
                        end
                    end else begin
                        dly_nxt = dly_r - 15'h0001;
                    end
                end
            end
            ST_HOST: begin
                if (seq_step_i) begin
                    state_nxt = ST_CONV;
                    dly_nxt   = `ACR_CONV_CYC;
                end else if (mode != 2'h2) begin
                    state_nxt = ST_TAIL;
                    dly_nxt   = fcd_len(fcd);
                end
            end
            ST_TAIL: begin
                if (cclk_tick) begin
                    if (dly_r <= 15'h0001) begin
                        if (tmr != 2'h0 && mode != 2'h0) begin
                            state_nxt = ST_WAIT;
                            int_nxt   = int_len(tmr);
                        end else begin
                            state_nxt = ST_IDLE;
                        end
                    end else begin
                        dly_nxt = dly_r - 15'h0001;
                    end
                end
            end
            ST_WAIT: begin
                if (mode == 2'h0 || tmr == 2'h0) begin
                    state_nxt = ST_IDLE;
                end else if (cclk_tick) begin
                    if (int_r <= 15'h0001) begin
                        state_nxt = ST_DELAY;
                        dly_nxt   = is_coord(ch) ? fcd_len(fcd) : 15'h0001;
                    end else begin
                        int_nxt = int_r - 15'h0001;
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r   <= ST_IDLE;
            dly_r     <= 15'h0000;
            int_r     <= 15'h0000;
            powered_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            dly_r     <= dly_nxt;
            int_r     <= int_nxt;
            powered_r <= powered_nxt;
        end
    end

    // outputs registered from state and fields
    always @(posedge clk_i) begin
        if (rst_i) begin
            convert_o               <= 1'b0;
            input_sel_o             <= 4'h0;
            single_or_ratiometric_o <= 1'b0;
            ext_ref_o               <= 1'b0;
            busy_o                  <= 1'b0;
            settle_o                <= 1'b0;
        end else begin
            convert_o <= (state_nxt == ST_CONV);
            // channel code passes to the mux
            // pressure and temperature codes pass unchanged
            input_sel_o <= ch;
            single_or_ratiometric_o <= ctrl1_r[`ACR_C1_SER];
            ext_ref_o <= ctrl2_r[`ACR_C2_REF];
            busy_o    <= (state_nxt != ST_IDLE);
            settle_o  <= (state_nxt == ST_DELAY) || (state_nxt == ST_TAIL);
        end
    end
endmodule // acr_ctrl

// File: design/acr_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
`define ACR_IDX_CTRL1      2'h1
`define ACR_IDX_CTRL2      2'h2
`define ACR_IDX_STATUS     2'h3
`define ACR_CTRL1_RST      12'h000
`define ACR_CTRL2_RST      12'h000
`define ACR_C1_MODE_LSB    0
`define ACR_C1_RD_LSB      2
`define ACR_C1_CH_LSB      7
`define ACR_C1_SER         11
`define ACR_C2_TMR_LSB     0
`define ACR_C2_REF         2
`define ACR_C2_POL         3
`define ACR_C2_FCD_LSB     4
`define ACR_INT_1024       15'h0400
`define ACR_INT_2048       15'h0800
`define ACR_INT_16384      15'h4000
`define ACR_FCD_1          15'h0001
`define ACR_FCD_256        15'h0100
`define ACR_FCD_2048       15'h0800
`define ACR_FCD_16384      15'h4000
`define ACR_CONV_CYC       15'h0010
`endif
